// file: psrw_power_ctrl.sv
`timescale 1ns/1ns

module psrw_power_ctrl (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        alternate_power_on_reset_n,
   input  wire logic        isolate_n,
   input  wire logic        bus_rst_n,
   input  wire logic        flash_addr_bit1,
   input  wire logic        link_valid,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_last,
   input  wire logic [4:0]  rx_class,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        we,
   input  wire logic        re,
   output logic      [31:0] rdata,
   output logic             pme_oe,
   output logic             internal_init,
   output logic             bus_out_en,
   output logic             master_en,
   output logic             slave_en,
   output logic             config_en,
   output logic             link_integrity_en,
   output logic             aux_supply_present
);

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                     alt_m;
      logic                     alt_s;
      logic                     iso_m;
      logic                     iso_s;
      logic                     brst_m;
      logic                     brst_s;
      logic                     iso_d;
      logic                     brst_d;
      logic                     link_d;
      psrw_pkg::psrw_state_t    state;
      logic                     bar_done;
      logic                     pme_en;
      logic                     pme_stat;
      logic                     link_wake_en;
      logic                     pat_en;
      logic [4:0]               class_en;
      logic                     aux;
      logic [6:0]               pat_addr;
      logic [7:0]               idx;
      logic                     v_d;
      logic                     last_d;
      logic                     inr_d;
      logic [7:0]               byte_d;
      logic [4:0]               cls_d;
      logic                     miss;
      logic                     matched;
      logic                     bus_oe;
      logic                     mst_en;
      logic                     slv_en;
      logic                     cfg_en;
      logic                     lnk_int;
      logic                     init;
      logic                     pme_oe;
      logic [31:0]              rdata;
   } psrw_st_t;

   psrw_st_t   s_reg;
   psrw_st_t   s_next;
   logic [8:0] pat_rdata;
   logic       mem_we;
   logic       bus_ok;
   logic       lowp;
   logic       brst_on;
   logic       brst_rise;
   logic       iso_rise;
   logic       init_cond;
   logic       link_chg;

   // ---------------------------------------------------------------
   // qualified bus conditions
   // ---------------------------------------------------------------
   // isolation masks the bus reset, so an unpowered bus cannot reset us
   assign bus_ok    = s_reg.iso_s & s_reg.brst_s;
   assign brst_on   = ~s_reg.brst_s & s_reg.iso_s & ~s_reg.aux;
   assign brst_rise = s_reg.brst_s & ~s_reg.brst_d & s_reg.iso_s
                      & ~s_reg.aux;
   assign iso_rise  = s_reg.iso_s & ~s_reg.iso_d;
   assign lowp      = (s_reg.state == psrw_pkg::D1) | (s_reg.state == psrw_pkg::D2)
                      | (s_reg.state == psrw_pkg::D3);
   assign link_chg  = link_valid ^ s_reg.link_d;
   assign init_cond = (brst_on & (s_reg.state != psrw_pkg::D3))
                      | (brst_rise & (s_reg.state == psrw_pkg::D3))
                      | iso_rise;
   assign mem_we    = we & bus_ok & (addr == psrw_pkg::OFF_PATDATA);

   // ---------------------------------------------------------------
   // pattern memory
   // ---------------------------------------------------------------
   psrw_pattern_mem u_pat (
      .clk    (clk),
      .arst_n (arst_n),
      .we     (mem_we),
      .waddr  (s_reg.pat_addr),
      .wdata  (wdata[8:0]),
      .raddr  (s_reg.idx[6:0]),
      .rdata  (pat_rdata)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       keep;
      logic       byte_miss;
      logic       miss_all;
      logic       hit;
      logic       wake;
      logic [1:0] ps_code;
      s_next    = s_reg;
      keep      = 1'b0;
      byte_miss = 1'b0;
      miss_all  = 1'b0;
      hit       = 1'b0;
      wake      = 1'b0;
      ps_code   = psrw_pkg::PS_D0;

      // two-flop synchronizers; iso/brst edge history from the second stage, link history from the raw input
      s_next.alt_m  = alternate_power_on_reset_n;
      s_next.alt_s  = s_reg.alt_m;
      s_next.iso_m  = isolate_n;
      s_next.iso_s  = s_reg.iso_m;
      s_next.brst_m = bus_rst_n;
      s_next.brst_s = s_reg.brst_m;
      s_next.iso_d  = s_reg.iso_s;
      s_next.brst_d = s_reg.brst_s;
      s_next.link_d = link_valid;

      // strap is caught while a reset is asserted
      if (!s_reg.alt_s || (!s_reg.brst_s && s_reg.iso_s)) begin
         s_next.aux = flash_addr_bit1;
      end

      // frame matcher: read address issued now, compare one cycle later
      byte_miss = s_reg.v_d & s_reg.inr_d & pat_rdata[psrw_pkg::PAT_MASK_BIT]
                  & (pat_rdata[7:0] != s_reg.byte_d);
      miss_all  = s_reg.miss | byte_miss;
      s_next.v_d    = rx_valid & lowp;
      s_next.byte_d = rx_byte;
      s_next.last_d = rx_last;
      s_next.cls_d  = rx_class;
      s_next.inr_d  = ~s_reg.idx[7];
      if (rx_valid && lowp) begin
         if (rx_last) begin
            s_next.idx = psrw_pkg::IDX_RST;
         end else if (!s_reg.idx[7]) begin
            s_next.idx = s_reg.idx + 8'h01;
         end
      end else if (!lowp) begin
         s_next.idx = psrw_pkg::IDX_RST;
      end
      if (s_reg.v_d) begin
         if (s_reg.last_d) begin
            hit = (s_reg.pat_en & ~miss_all)
                  | (|(s_reg.cls_d & s_reg.class_en));
            s_next.miss    = 1'b0;
            s_next.matched = hit;
         end else begin
            s_next.miss = miss_all;
         end
      end
      if (!lowp) begin
         s_next.miss = 1'b0;
      end

      // packets wake only in low power with a live link; link changes always
      wake = s_reg.pme_en & ((hit & lowp & link_valid)
             | (link_chg & s_reg.link_wake_en));

      // register writes; isolation and bus reset make the port deaf
      if (we && bus_ok) begin
         case (addr)
            psrw_pkg::OFF_PMCS: begin
               s_next.pme_en = wdata[psrw_pkg::PMCS_PME_EN_BIT];
               if (wdata[psrw_pkg::PMCS_PME_STAT_BIT]) begin
                  s_next.pme_stat = 1'b0;
               end
               case (wdata[1:0])
                  psrw_pkg::PS_D1: s_next.state = psrw_pkg::D1;
                  psrw_pkg::PS_D2: s_next.state = psrw_pkg::D2;
                  psrw_pkg::PS_D3: s_next.state = psrw_pkg::D3;
                  default: begin
                     s_next.state = s_reg.bar_done ? psrw_pkg::D0A : psrw_pkg::D0U;
                  end
               endcase
            end
            psrw_pkg::OFF_WAKECFG: begin
               s_next.link_wake_en = wdata[psrw_pkg::WCFG_LINK_BIT];
               s_next.pat_en       = wdata[psrw_pkg::WCFG_PAT_BIT];
               s_next.class_en     = wdata[psrw_pkg::WCFG_CLASS_LSB +: psrw_pkg::NUM_CLASS];
            end
            psrw_pkg::OFF_BAR: begin
               s_next.bar_done = 1'b1;
               if (s_reg.state == psrw_pkg::D0U) begin
                  s_next.state = psrw_pkg::D0A;
               end
            end
            psrw_pkg::OFF_PATADDR: s_next.pat_addr = wdata[6:0];
            psrw_pkg::OFF_PATDATA: s_next.pat_addr = s_reg.pat_addr + 7'h01;
            default: ;
         endcase
      end

      // a wake event beats a same-cycle clear
      if (wake) begin
         s_next.pme_stat = 1'b1;
      end

      // internal initialization; enabled wake context is left alone
      keep = s_reg.pme_en | ((s_reg.state == psrw_pkg::D3) & brst_rise);
      if (init_cond) begin
         s_next.state    = psrw_pkg::D0U;
         s_next.bar_done = 1'b0;
         s_next.pat_addr = psrw_pkg::PAT_ADDR_RST;
         s_next.idx      = psrw_pkg::IDX_RST;
         s_next.miss     = 1'b0;
         s_next.matched  = 1'b0;
         if (!keep) begin
            s_next.pme_en       = 1'b0;
            s_next.pme_stat     = 1'b0;
            s_next.link_wake_en = 1'b0;
            s_next.pat_en       = 1'b0;
            s_next.class_en     = 5'h00;
         end
      end

      // read data, present only in the cycle after the strobe
      case (s_reg.state)
         psrw_pkg::D1: ps_code = psrw_pkg::PS_D1;
         psrw_pkg::D2: ps_code = psrw_pkg::PS_D2;
         psrw_pkg::D3: ps_code = psrw_pkg::PS_D3;
         default:      ps_code = psrw_pkg::PS_D0;
      endcase
      s_next.rdata = 32'h0000_0000;
      if (re && bus_ok) begin
         case (addr)
            psrw_pkg::OFF_PMCS: begin
               s_next.rdata[1:0] = ps_code;
               s_next.rdata[psrw_pkg::PMCS_PME_EN_BIT]   = s_reg.pme_en;
               s_next.rdata[psrw_pkg::PMCS_PME_STAT_BIT] = s_reg.pme_stat;
            end
            psrw_pkg::OFF_WAKECFG: begin
               s_next.rdata[psrw_pkg::WCFG_LINK_BIT] = s_reg.link_wake_en;
               s_next.rdata[psrw_pkg::WCFG_PAT_BIT]  = s_reg.pat_en;
               s_next.rdata[psrw_pkg::WCFG_CLASS_LSB +: psrw_pkg::NUM_CLASS] = s_reg.class_en;
            end
            psrw_pkg::OFF_BAR: s_next.rdata[0] = s_reg.bar_done;
            psrw_pkg::OFF_STATUS: begin
               s_next.rdata[psrw_pkg::STAT_AUX_BIT]    = s_reg.aux;
               s_next.rdata[psrw_pkg::STAT_LINK_BIT]   = s_reg.link_d;
               s_next.rdata[psrw_pkg::STAT_ACTIVE_BIT] = (s_reg.state == psrw_pkg::D0A);
               s_next.rdata[psrw_pkg::STAT_MATCH_BIT]  = s_reg.matched;
            end
            psrw_pkg::OFF_PATADDR: s_next.rdata[6:0] = s_reg.pat_addr;
            psrw_pkg::OFF_PMCAP: s_next.rdata[psrw_pkg::PMCAP_AUX_BIT] = s_reg.aux;
            default: ;
         endcase
      end

      // alternate reset: record back to zero except synchronizers, edge history and the recaptured strap
      if (!s_reg.alt_s) begin
         s_next        = '0;
         s_next.alt_m  = alternate_power_on_reset_n;
         s_next.alt_s  = s_reg.alt_m;
         s_next.iso_m  = isolate_n;
         s_next.iso_s  = s_reg.iso_m;
         s_next.brst_m = bus_rst_n;
         s_next.brst_s = s_reg.brst_m;
         s_next.iso_d  = s_reg.iso_s;
         s_next.brst_d = s_reg.brst_s;
         s_next.link_d = link_valid;
         s_next.aux    = flash_addr_bit1;
      end

      // pin controls follow the settled next state
      s_next.bus_oe  = s_next.iso_s & s_next.brst_s;
      s_next.cfg_en  = s_next.bus_oe;
      s_next.mst_en  = s_next.bus_oe & (s_next.state == psrw_pkg::D0A);
      s_next.slv_en  = s_next.bus_oe & ((s_next.state == psrw_pkg::D0A)
                       | (s_next.state == psrw_pkg::D0U));
      // no link upkeep while down in D2/D3, nor in low power without wake
      s_next.lnk_int = ~(((s_next.state == psrw_pkg::D2) | (s_next.state == psrw_pkg::D3))
                       & ~link_valid)
                       & ~((s_next.state != psrw_pkg::D0U) & (s_next.state != psrw_pkg::D0A)
                       & ~s_next.pme_en);
      s_next.init    = init_cond & s_reg.alt_s;
      s_next.pme_oe  = s_next.pme_stat & s_next.pme_en;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata              = s_reg.rdata;
   assign pme_oe             = s_reg.pme_oe;
   assign internal_init      = s_reg.init;
   assign bus_out_en         = s_reg.bus_oe;
   assign master_en          = s_reg.mst_en;
   assign slave_en           = s_reg.slv_en;
   assign config_en          = s_reg.cfg_en;
   assign link_integrity_en  = s_reg.lnk_int;
   assign aux_supply_present = s_reg.aux;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   d1_no_master_a: assert property (@(posedge clk) disable iff (!arst_n)
      s_reg.mst_en |-> $past(s_reg.state) != psrw_pkg::D1 || s_reg.state == psrw_pkg::D0A)
      else $error("bus mastering outside the active state");
   iso_float_a: assert property (@(posedge clk) disable iff (!arst_n)
      !s_reg.iso_s |-> !s_reg.bus_oe && !s_reg.cfg_en)
      else $error("bus outputs enabled while isolated");
   pme_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      s_reg.pme_oe |-> s_reg.pme_en && s_reg.pme_stat)
      else $error("wake output without enable");
   bar_active_a: assert property (@(posedge clk) disable iff (!arst_n)
      (we && bus_ok && addr == psrw_pkg::OFF_BAR && s_reg.alt_s && !init_cond
       && s_reg.state == psrw_pkg::D0U) |=> s_reg.state == psrw_pkg::D0A)
      else $error("base address write did not activate");
   iso_init_a: assert property (@(posedge clk) disable iff (!arst_n)
      (s_reg.iso_s && !s_reg.iso_d && s_reg.alt_s) |=> s_reg.init ##1 s_reg.state != psrw_pkg::D0A)
      else $error("isolate release did not initialize");
   aux_no_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
      (s_reg.aux && s_reg.iso_s && s_reg.iso_d && s_reg.alt_s) |=> !s_reg.init)
      else $error("bus reset acted with aux supply present");
   link_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
      (link_chg && s_reg.pme_en && s_reg.link_wake_en && s_reg.alt_s && !init_cond)
      |=> s_reg.pme_oe [*2])
      else $error("link change did not raise wake");
   d3_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
      (s_reg.state == psrw_pkg::D3 && brst_rise && s_reg.pme_stat && s_reg.alt_s
       && !iso_rise) |=> s_reg.pme_stat && s_reg.state == psrw_pkg::D0U)
      else $error("wake context lost on D3 reset release");
   strap_a: assert property (@(posedge clk) disable iff (!arst_n)
      !s_reg.alt_s |=> s_reg.aux == $past(flash_addr_bit1))
      else $error("strap not latched during reset");
   alt_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
      !s_reg.alt_s |=> s_reg.state == psrw_pkg::D0U && !s_reg.pme_en && !s_reg.pme_oe)
      else $error("alternate reset left state behind");
   no_integrity_a: assert property (@(posedge clk) disable iff (!arst_n)
      s_reg.lnk_int |-> !(s_reg.state == psrw_pkg::D2 && !$past(link_valid)))
      else $error("link upkeep while link down in D2");

endmodule : psrw_power_ctrl

// file: psrw_pkg.sv
package psrw_pkg;

   // ---------------------------------------------------------------
   // power states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {D0U, D0A, D1, D2, D3} psrw_state_t;

   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D1 = 2'h1;
   localparam logic [1:0] PS_D2 = 2'h2;
   localparam logic [1:0] PS_D3 = 2'h3;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_PMCS    = 8'h00;
   localparam logic [7:0] OFF_WAKECFG = 8'h04;
   localparam logic [7:0] OFF_BAR     = 8'h08;
   localparam logic [7:0] OFF_STATUS  = 8'h0c;
   localparam logic [7:0] OFF_PATADDR = 8'h10;
   localparam logic [7:0] OFF_PATDATA = 8'h14;
   localparam logic [7:0] OFF_PMCAP   = 8'h18;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PMCS_PME_EN_BIT   = 8;
   localparam int PMCS_PME_STAT_BIT = 15;
   localparam int WCFG_LINK_BIT     = 0;
   localparam int WCFG_PAT_BIT      = 1;
   localparam int WCFG_CLASS_LSB    = 2;
   localparam int STAT_AUX_BIT      = 0;
   localparam int STAT_LINK_BIT     = 1;
   localparam int STAT_ACTIVE_BIT   = 2;
   localparam int STAT_MATCH_BIT    = 3;
   localparam int PMCAP_AUX_BIT     = 15;
   localparam int PAT_MASK_BIT      = 8;

   // ---------------------------------------------------------------
   // sizes and reset values
   // ---------------------------------------------------------------
   localparam int NUM_CLASS = 5;
   localparam int PAT_DEPTH = 128;
   localparam int PAT_AW    = 7;
   localparam int PAT_DW    = 9;
   localparam int IDX_W     = 8;

   localparam logic [6:0] PAT_ADDR_RST = 7'h00;
   localparam logic [7:0] IDX_RST      = 8'h00;

endpackage : psrw_pkg

// file: psrw_pattern_mem.sv
`timescale 1ns/1ns

// wake pattern store: mask bit over compare byte, one entry per frame byte
module psrw_pattern_mem (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       we,
   input  wire logic [6:0] waddr,
   input  wire logic [8:0] wdata,
   input  wire logic [6:0] raddr,
   output logic      [8:0] rdata
);

   logic [8:0] mem_q [psrw_pkg::PAT_DEPTH];

   // ---------------------------------------------------------------
   // write port; contents survive every reset so wake context is kept
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // registered read, one cycle latency
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 9'h000;
      end else begin
         rdata <= mem_q[raddr];
      end
   end

endmodule : psrw_pattern_mem

// file: psrw_host_model.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// host power-good and bus reset supervisor
// ---------------------------------------------------------------
module psrw_host_model (
   input  wire logic clk,
   input  wire logic pg_req,
   input  wire logic rst_req,
   input  wire logic alt_req,
   input  wire logic aux_req,
   output logic      isolate_n = 1'b0,
   output logic      bus_rst_n = 1'b0,
   output logic      alternate_power_on_reset_n = 1'b0,
   output logic      flash_addr_bit1 = 1'b0
);
   // power good feeds isolate and envelopes bus reset, so reset never rises while unpowered
   always @(posedge clk) begin
      isolate_n                  <= pg_req;
      bus_rst_n                  <= pg_req & ~rst_req;
      alternate_power_on_reset_n <= ~alt_req;
      flash_addr_bit1            <= aux_req;             // pull-up fitted only on aux supply
   end
endmodule : psrw_host_model

// file: pci_power_state_reset_wake_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module pci_power_state_reset_wake_tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        link_valid = 1'b1;
   logic        rx_valid = 1'b0;
   logic        rx_last = 1'b0;
   logic        we = 1'b0;
   logic        re = 1'b0;
   logic        pg_req = 1'b1;
   logic        rst_req = 1'b0;
   logic        alt_req = 1'b0;
   logic        aux_req = 1'b0;
   logic [7:0]  rx_byte = 8'h00;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rd, rdata;
   logic        s, iso_n, brst_n, alt_n, strap, pme_oe, internal_init, bus_out_en;
   logic        master_en, slave_en, config_en, link_integrity_en, aux_supply_present;
   int          n_errors = 0;
   int          check_count = 0;
   int          cyc = 0;

   psrw_host_model i_host (.clk(clk), .pg_req(pg_req), .rst_req(rst_req), .alt_req(alt_req),
      .aux_req(aux_req), .isolate_n(iso_n), .bus_rst_n(brst_n),
      .alternate_power_on_reset_n(alt_n), .flash_addr_bit1(strap));

   psrw_power_ctrl i_dut (.clk(clk), .arst_n(arst_n), .alternate_power_on_reset_n(alt_n),
      .isolate_n(iso_n), .bus_rst_n(brst_n), .flash_addr_bit1(strap), .link_valid(link_valid),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_class(5'h00),
      .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pme_oe(pme_oe),
      .internal_init(internal_init), .bus_out_en(bus_out_en), .master_en(master_en),
      .slave_en(slave_en), .config_en(config_en), .link_integrity_en(link_integrity_en),
      .aux_supply_present(aux_supply_present));

   // ---------------------------------------------------------------
   // clock, hang guard and shared bus tasks
   // ---------------------------------------------------------------
   always #25 clk = ~clk;

   // ceiling is about fourteen times the expected run, so a stuck wait cannot hang the job
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask : rdr

   task automatic frame(input logic [7:0] b3);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_byte <= (i == 3) ? b3 : 8'(8'ha0 + i);
         rx_last <= (i == 3);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
   endtask : frame

   // init from an edge may be a single cycle, so every cycle is looked at
   task automatic seen_init(output logic f);
      f = 1'b0;
      repeat (8) begin
         step(1);
         if (internal_init === 1'b1) f = 1'b1;
      end
   endtask : seen_init

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_init;
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h2)
      `CHK(master_en, 1'b0)
      wr(psrw_pkg::OFF_BAR, 32'h1);
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h6)
      `CHK(master_en, 1'b1)
      rdr(8'hfc, rd); `CHK(rd, 32'h0)
      rdr(psrw_pkg::OFF_PMCAP, rd); `CHK(rd, 32'h0)
   endtask : t_init

   task automatic t_link;
      wr(psrw_pkg::OFF_WAKECFG, 32'h1);
      @(posedge clk) link_valid <= 1'b0;
      step(3); `CHK(pme_oe, 1'b0)
      wr(psrw_pkg::OFF_PMCS, 32'h100);
      @(posedge clk) link_valid <= 1'b1;
      step(2); `CHK(pme_oe, 1'b1)
      @(posedge clk) alt_req <= 1'b1;
      step(6);
      @(posedge clk) alt_req <= 1'b0;
      step(6); `CHK(pme_oe, 1'b0)
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h2)
   endtask : t_link

   task automatic t_pat;
      wr(psrw_pkg::OFF_PATADDR, 32'h0);
      for (int i = 0; i < 128; i++)
         wr(psrw_pkg::OFF_PATDATA, (i < 4) ? 32'(9'h1a0 + i) : 32'h0);
      wr(psrw_pkg::OFF_WAKECFG, 32'h2);
      wr(psrw_pkg::OFF_PMCS, 32'h101);
      step(1); `CHK(master_en, 1'b0)
      `CHK(slave_en, 1'b0)
      `CHK(config_en, 1'b1)
      `CHK(link_integrity_en, 1'b1)
      frame(8'h55);
      step(3); `CHK(pme_oe, 1'b0)
      frame(8'ha3);
      step(3); `CHK(pme_oe, 1'b1)
      wr(psrw_pkg::OFF_PMCS, 32'h8103);
      @(posedge clk) link_valid <= 1'b0;
      step(3); `CHK(pme_oe, 1'b0)
      `CHK(link_integrity_en, 1'b0)
      @(posedge clk) rst_req <= 1'b1;
      step(6); `CHK(internal_init, 1'b0)
      `CHK(bus_out_en, 1'b0)
      @(posedge clk) rst_req <= 1'b0;
      seen_init(s); `CHK(s, 1'b1)
      rdr(psrw_pkg::OFF_PMCS, rd); `CHK(rd & 32'h100, 32'h100)
   endtask : t_pat

   task automatic t_bus;
      @(posedge clk) link_valid <= 1'b1;
      @(posedge clk) rst_req <= 1'b1;
      step(6); `CHK(internal_init, 1'b1)
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h0)
      @(posedge clk) rst_req <= 1'b0;
      step(6); `CHK(bus_out_en, 1'b1)
      @(posedge clk) pg_req <= 1'b0;
      step(6); `CHK(bus_out_en, 1'b0)
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h0)
      @(posedge clk) pg_req <= 1'b1;
      seen_init(s); `CHK(s, 1'b1)
   endtask : t_bus

   task automatic t_aux;
      @(posedge clk) aux_req <= 1'b1;
      alt_req <= 1'b1;
      step(6);
      @(posedge clk) alt_req <= 1'b0;
      step(6);
      rdr(psrw_pkg::OFF_PMCAP, rd); `CHK(rd, 32'h8000)
      rdr(psrw_pkg::OFF_STATUS, rd); `CHK(rd, 32'h3)
      `CHK(aux_supply_present, 1'b1)
      @(posedge clk) rst_req <= 1'b1;
      step(6); `CHK(internal_init, 1'b0)
      @(posedge clk) rst_req <= 1'b0;
      step(6);
   endtask : t_aux

   task automatic report_and_stop;
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // main sequence: reset held 12 cycles, synchronizers settle, then scenarios
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      step(4);
      t_init();
      t_link();
      t_pat();
      t_bus();
      t_aux();
      report_and_stop();
   end
endmodule : pci_power_state_reset_wake_tb
